// ==== src/csda_core.sv ====
// compare-and-skip and decimal adjust execution on the four-quarter cycle
`timescale 1ns/1ps
module csda_core
  import csda_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        nrst,
  // instruction stream
  input  wire logic [15:0] instr_word,
  input  wire logic        next_two_word,
  input  wire logic        ext_set_en,
  // core state
  input  wire logic [7:0]  working_register,
  input  wire logic [3:0]  bank_select_register,
  input  wire logic [11:0] index_base,
  input  wire logic        carry_flag,
  input  wire logic        digit_carry_flag,
  // data memory
  input  wire logic [7:0]  mem_rdata,
  output logic [11:0]      mem_addr_reg,
  output logic             mem_rd_reg,
  // write back
  output logic [7:0]       wk_wdata_reg,
  output logic             wk_we_reg,
  output logic             carry_wdata_reg,
  output logic             carry_we_reg,
  // sequencing
  output logic [1:0]       quarter_reg,
  output logic             flush_reg,
  output logic             nop_cycle_reg,
  output logic             pc_incr_reg
);

  csda_state_t state_reg;        // execute or inserted cycles
  logic        gt_reg;           // greater compare in flight
  logic        lt_reg;           // less compare in flight
  logic        dadj_reg;         // decimal adjust in flight
  logic [7:0]  operand_reg;      // byte read in q2
  logic        skip_pend_reg;    // skip decided in q3
  logic        two_reg;          // skipped word is two long
  logic        is_exec;          // executing, not inserted

  assign is_exec = (state_reg == CSDA_ST_EXEC);

  // operand address; low part of access bank (f<=5Fh) may be indexed
  function automatic logic [11:0] op_addr(input logic [15:0] iw, input logic ext, input logic [3:0] bsel,
                                          input logic [11:0] base);
    logic [7:0] f;
    f = iw[7:0];
    if (iw[8]) begin
      return {bsel, f}; // [RULE5]
    end else if (ext && (f <= CSDA_IDX_LIMIT)) begin
      return 12'(base + {4'h0, f}); // [RULE6]
    end else if (f <= CSDA_IDX_LIMIT) begin
      return {CSDA_ACC_LOW, f}; // [RULE5]
    end
    return {CSDA_ACC_HIGH, f}; // [RULE5]
  endfunction : op_addr

  // either compare pattern; bit a is left out of the match
  function automatic logic is_cmp(input logic [15:0] iw);
    return (iw[15:9] == CSDA_OP_GT) || (iw[15:9] == CSDA_OP_LT);
  endfunction : is_cmp

  // free-running quarter counter
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      quarter_reg <= CSDA_Q1;
    end else begin
      quarter_reg <= 2'(quarter_reg + 2'h1);
    end
  end

  // decode in q1; only one word is consumed per instruction
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      gt_reg   <= 1'b0;
      lt_reg   <= 1'b0;
      dadj_reg <= 1'b0;
    end else if (quarter_reg == CSDA_Q1) begin
      gt_reg   <= is_exec && (instr_word[15:9] == CSDA_OP_GT); // [RULE1] [RULE8]
      lt_reg   <= is_exec && (instr_word[15:9] == CSDA_OP_LT); // [RULE3] [RULE8]
      dadj_reg <= is_exec && (instr_word == CSDA_OP_DADJ); // [RULE10]
    end
  end

  // data read strobe stands for q2 only
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      mem_addr_reg <= 12'h000;
      mem_rd_reg   <= 1'b0;
    end else if (quarter_reg == CSDA_Q1) begin
      // address decoded even for other opcodes, harmless without the strobe
      mem_addr_reg <= op_addr(instr_word, ext_set_en, bank_select_register, index_base);
      mem_rd_reg   <= is_exec && is_cmp(instr_word); // [RULE1] [RULE3]
    end else begin
      mem_rd_reg   <= 1'b0;
    end
  end

  // capture the read byte at the end of q2
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      operand_reg <= 8'h00;
    end else if ((quarter_reg == CSDA_Q2) && (gt_reg || lt_reg)) begin
      operand_reg <= mem_rdata;
    end
  end

  // unsigned compare in q3; no status flag is touched
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      skip_pend_reg <= 1'b0;
      two_reg       <= 1'b0;
      flush_reg     <= 1'b0;
    end else if ((quarter_reg == CSDA_Q3) && is_exec) begin
      skip_pend_reg <= (gt_reg && (operand_reg > working_register)) || // [RULE2]
                       (lt_reg && (operand_reg < working_register)); // [RULE4]
      flush_reg     <= (gt_reg && (operand_reg > working_register)) ||
                       (lt_reg && (operand_reg < working_register));
      two_reg       <= next_two_word; // [RULE7]
    end else begin
      flush_reg     <= 1'b0;
    end
  end

  // decimal adjust result written during q4
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wk_wdata_reg    <= 8'h00;
      wk_we_reg       <= 1'b0;
      carry_wdata_reg <= 1'b0;
      carry_we_reg    <= 1'b0;
    end else if ((quarter_reg == CSDA_Q3) && is_exec && dadj_reg) begin
      {carry_wdata_reg, wk_wdata_reg} <= csda_dec_adj(working_register, carry_flag, // [RULE11] [RULE12]
                                                      digit_carry_flag);
      wk_we_reg       <= 1'b1;
      carry_we_reg    <= 1'b1; // [RULE12]
    end else begin
      wk_we_reg       <= 1'b0;
      carry_we_reg    <= 1'b0;
    end
  end

  // one word step per cycle, inserted cycles included
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pc_incr_reg <= 1'b0;
    end else begin
      pc_incr_reg <= (quarter_reg == CSDA_Q3); // [RULE8]
    end
  end

  // inserted cycles: one, or two when the skipped word is long
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_reg     <= CSDA_ST_EXEC;
      nop_cycle_reg <= 1'b0;
    end else if (quarter_reg == CSDA_Q4) begin
      unique case (state_reg)
        CSDA_ST_EXEC: begin
          state_reg     <= skip_pend_reg ? CSDA_ST_SKIP1 : CSDA_ST_EXEC; // [RULE7]
          nop_cycle_reg <= skip_pend_reg; // [RULE9]
        end
        CSDA_ST_SKIP1: begin
          state_reg     <= two_reg ? CSDA_ST_SKIP2 : CSDA_ST_EXEC; // [RULE9]
          nop_cycle_reg <= two_reg;
        end
        CSDA_ST_SKIP2: begin
          state_reg     <= CSDA_ST_EXEC;
          nop_cycle_reg <= 1'b0;
        end
        // spare code of the two-bit state: fall back to executing
        default: begin
          state_reg     <= CSDA_ST_EXEC;
          nop_cycle_reg <= 1'b0;
        end
      endcase
    end
  end

  // helper: a compare in q1 of an executing cycle
  logic cmp_q1;
  assign cmp_q1 = (quarter_reg == CSDA_Q1) && is_exec && is_cmp(instr_word);

  sequence s_one_insert;
    nop_cycle_reg [*4] ##1 !nop_cycle_reg;
  endsequence

  sequence s_two_insert;
    nop_cycle_reg [*8] ##1 !nop_cycle_reg;
  endsequence

  AST_DECODE_GT: assert property (@(posedge core_clk) disable iff (!nrst) // [RULE1]
    ((quarter_reg == CSDA_Q1) && is_exec && (instr_word[15:9] == CSDA_OP_GT))
    |=> (gt_reg && mem_rd_reg) ##1 !mem_rd_reg)
    else $error("greater compare not decoded");

  AST_DECODE_LT: assert property (@(posedge core_clk) disable iff (!nrst) // [RULE3]
    ((quarter_reg == CSDA_Q1) && is_exec && (instr_word[15:9] == CSDA_OP_LT)) |=> lt_reg && mem_rd_reg)
    else $error("less compare not decoded");

  AST_GT_SKIP: assert property (@(posedge core_clk) disable iff (!nrst) // [RULE2]
    ((quarter_reg == CSDA_Q3) && is_exec && gt_reg) |=> (flush_reg == ($past(operand_reg) > $past(working_register))))
    else $error("greater compare skip wrong");

  AST_LT_SKIP: assert property (@(posedge core_clk) disable iff (!nrst) // [RULE4]
    ((quarter_reg == CSDA_Q3) && is_exec && lt_reg) |=> (flush_reg == ($past(operand_reg) < $past(working_register))))
    else $error("less compare skip wrong");

  AST_FLAGS_KEPT: assert property (@(posedge core_clk) disable iff (!nrst) // [RULE4]
    (mem_rd_reg) |-> ##2 (!carry_we_reg && !wk_we_reg))
    else $error("compare wrote a flag");

  AST_BANK_SEL: assert property (@(posedge core_clk) disable iff (!nrst) // [RULE5]
    (cmp_q1 && instr_word[8]) |=> (mem_addr_reg == {$past(bank_select_register), $past(instr_word[7:0])}))
    else $error("bank select address wrong");

  AST_INDEXED: assert property (@(posedge core_clk) disable iff (!nrst) // [RULE6]
    (cmp_q1 && !instr_word[8] && ext_set_en && (instr_word[7:0] <= CSDA_IDX_LIMIT))
    |=> (mem_addr_reg == 12'($past(index_base) + {4'h0, $past(instr_word[7:0])})))
    else $error("indexed address wrong");

  AST_SKIP_ONE: assert property (@(posedge core_clk) disable iff (!nrst) // [RULE7]
    (flush_reg && !two_reg) |=> s_one_insert)
    else $error("single skip length wrong");

  AST_SKIP_TWO: assert property (@(posedge core_clk) disable iff (!nrst) // [RULE7]
    (flush_reg && two_reg) |=> s_two_insert)
    else $error("double skip length wrong");

  AST_NOP_QUIET: assert property (@(posedge core_clk) disable iff (!nrst) // [RULE9]
    nop_cycle_reg |-> !mem_rd_reg && !wk_we_reg && !carry_we_reg && !flush_reg)
    else $error("inserted cycle did work");

  AST_ONE_WORD: assert property (@(posedge core_clk) disable iff (!nrst) // [RULE8]
    pc_incr_reg |=> !pc_incr_reg [*3] ##1 pc_incr_reg)
    else $error("program step not one word per cycle");

  AST_DADJ: assert property (@(posedge core_clk) disable iff (!nrst) // [RULE11]
    ((quarter_reg == CSDA_Q3) && is_exec && dadj_reg)
    |=> wk_we_reg && carry_we_reg &&
        ({carry_wdata_reg, wk_wdata_reg} == csda_dec_adj($past(working_register), $past(carry_flag),
                                                          $past(digit_carry_flag))))
    else $error("decimal adjust result wrong");

  AST_DADJ_DECODE: assert property (@(posedge core_clk) disable iff (!nrst) // [RULE10]
    ((quarter_reg == CSDA_Q1) && is_exec && (instr_word == CSDA_OP_DADJ)) |-> ##3 wk_we_reg)
    else $error("decimal adjust not executed");

endmodule : csda_core

// ==== src/csda_pkg.sv ====
// Function
// RULE1 - decode greater compare, pattern 0110 010a
// RULE2 - skip next when byte above working register
// RULE3 - decode less compare, pattern 0110 000a
// RULE4 - skip when byte below; flags untouched
// RULE5 - a=0 access bank, a=1 bank select
// RULE6 - indexed offset: a=0, extended, f<=5Fh
// RULE7 - one cycle, two on skip, three long
// RULE8 - each compare is one program word
// RULE9 - inserted skip cycles do nothing at all; pc_incr_reg still pulses and mem_addr_reg still loads in them
// RULE10 - decode decimal adjust, fixed pattern 0007h
// RULE11 - upper nibble: add six if over nine
// RULE12 - lower nibble: add six; carry updated
package csda_pkg;

  // quarter phases of the instruction cycle
  localparam logic [1:0] CSDA_Q1 = 2'h0;
  localparam logic [1:0] CSDA_Q2 = 2'h1;
  localparam logic [1:0] CSDA_Q3 = 2'h2;
  localparam logic [1:0] CSDA_Q4 = 2'h3;

  // opcode patterns, compares match the upper seven bits
  localparam logic [6:0]  CSDA_OP_GT   = 7'h32;
  localparam logic [6:0]  CSDA_OP_LT   = 7'h30;
  localparam logic [15:0] CSDA_OP_DADJ = 16'h0007;

  // addressing constants
  localparam logic [7:0] CSDA_IDX_LIMIT  = 8'h5F;
  localparam logic [3:0] CSDA_ACC_HIGH   = 4'hF;
  localparam logic [3:0] CSDA_ACC_LOW    = 4'h0;

  // decimal adjust constants
  localparam logic [4:0] CSDA_BCD_MAX = 5'h09;
  localparam logic [4:0] CSDA_BCD_FIX = 5'h06;

  // sequencer states
  typedef enum logic [1:0] {
    CSDA_ST_EXEC,
    CSDA_ST_SKIP1,
    CSDA_ST_SKIP2
  } csda_state_t;

  // decimal adjust: returns {carry, result}
  function automatic logic [8:0] csda_dec_adj(input logic [7:0] w, input logic c, input logic dcf);
    logic [4:0] lo;
    logic [4:0] hi;
    logic       dcy;
    lo = {1'b0, w[3:0]};
    if ((lo > CSDA_BCD_MAX) || dcf) begin
      lo = lo + CSDA_BCD_FIX;
    end
    dcy = lo[4];
    hi = {1'b0, w[7:4]} + {4'h0, dcy};
    if ((hi > CSDA_BCD_MAX) || c) begin
      hi = hi + CSDA_BCD_FIX;
    end
    return {hi[4] | c, hi[3:0], lo[3:0]};
  endfunction : csda_dec_adj

endpackage : csda_pkg

// ==== verif/tb_top.sv ====
// self-checking bench for the compare-skip and decimal adjust block
`timescale 1ns/1ps
module tb_top;
  import csda_pkg::*;
  // clock, reset and instruction side
  logic        core_clk, nrst, next_two_word, ext_set_en, carry_flag, digit_carry_flag;
  logic [15:0] instr_word;
  logic [7:0]  working_register, mem_rdata, wk_wdata_reg;
  logic [3:0]  bank_select_register;
  logic [11:0] index_base, mem_addr_reg;
  // registered outputs
  logic        mem_rd_reg, wk_we_reg, carry_wdata_reg, carry_we_reg, flush_reg, nop_cycle_reg, pc_incr_reg;
  logic [1:0]  quarter_reg;
  // score keeping
  int          bad_count, tests_run, cycles;

  csda_core i_csda_core (.core_clk(core_clk), .nrst(nrst), .instr_word(instr_word), .next_two_word(next_two_word),
    .ext_set_en(ext_set_en), .working_register(working_register), .bank_select_register(bank_select_register),
    .index_base(index_base), .carry_flag(carry_flag), .digit_carry_flag(digit_carry_flag), .mem_rdata(mem_rdata),
    .mem_addr_reg(mem_addr_reg), .mem_rd_reg(mem_rd_reg), .wk_wdata_reg(wk_wdata_reg), .wk_we_reg(wk_we_reg),
    .carry_wdata_reg(carry_wdata_reg), .carry_we_reg(carry_we_reg), .quarter_reg(quarter_reg),
    .flush_reg(flush_reg), .nop_cycle_reg(nop_cycle_reg), .pc_incr_reg(pc_incr_reg));

  // 125 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // verdict and end of run
  task automatic close_out;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : close_out

  // one comparison, widened so every field fits one task
  task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("BAD %s expected %h seen %h", what, exp, got);
      bad_count++;
    end
  endtask : chk

  // one instruction cycle; expectations worked out here, not taken from the block
  task automatic exec(input logic [15:0] iw, input logic [7:0] w, rd, input logic c, dcf, two, ext);
    logic       cmp, dadj, skp;
    logic [11:0] adr;
    logic [4:0] lo, hi;
    int         n, act;
    cmp = (iw[15:9] == 7'h32) || (iw[15:9] == 7'h30);
    dadj = (iw == 16'h0007);
    // bit 10 tells the greater pattern from the less one
    skp = cmp && (iw[10] ? (rd > w) : (rd < w));
    if (iw[8]) adr = {bank_select_register, iw[7:0]};
    else if (iw[7:0] <= 8'h5F) adr = ext ? index_base + {4'h0, iw[7:0]} : {4'h0, iw[7:0]};
    else adr = {4'hF, iw[7:0]};
    lo = {1'b0, w[3:0]};
    if (lo > 5'h09 || dcf) lo = lo + 5'h06;
    hi = {1'b0, w[7:4]} + {4'h0, lo[4]};
    if (hi > 5'h09 || c) hi = hi + 5'h06;
    n = 0;
    // wait for a fresh cycle start outside inserted cycles
    while (!(quarter_reg === 2'h0 && nop_cycle_reg === 1'b0) && n < 40) begin
      @(negedge core_clk);
      n++;
    end
    instr_word = iw;
    working_register = w;
    mem_rdata = rd;
    carry_flag = c;
    digit_carry_flag = dcf;
    next_two_word = two;
    ext_set_en = ext;
    @(negedge core_clk);
    chk("mem_rd", 12'(cmp), 12'(mem_rd_reg));
    if (cmp) chk("addr", adr, mem_addr_reg);
    repeat (2) @(negedge core_clk);
    chk("flush", 12'(skp), 12'(flush_reg));
    chk("w_we", 12'(dadj), 12'(wk_we_reg));
    chk("c_we", 12'(dadj), 12'(carry_we_reg));
    if (dadj) chk("w_data", {4'h0, hi[3:0], lo[3:0]}, 12'(wk_wdata_reg));
    if (dadj) chk("c_data", 12'(hi[4] | c), 12'(carry_wdata_reg));
    chk("pc_incr", 12'h001, 12'(pc_incr_reg));
    chk("quarter", 12'h003, 12'(quarter_reg));
    instr_word = 16'h0000;
    n = 0;
    act = 0;
    // inserted cycles: count them and watch that no read, write or flush happens inside
    // the same word is offered again while inserted, and must be refused
    repeat (8) begin
      @(negedge core_clk);
      if (nop_cycle_reg === 1'b1) n++;
      if (mem_rd_reg !== 1'b0 || wk_we_reg !== 1'b0 || carry_we_reg !== 1'b0 || flush_reg !== 1'b0) act++;
      instr_word = (nop_cycle_reg === 1'b1) ? iw : 16'h0000;
    end
    chk("nop_clocks", skp ? (two ? 12'h008 : 12'h004) : 12'h000, 12'(n));
    chk("idle_act", 12'h000, 12'(act));
    $display("test done %h", iw);
  endtask : exec

  // runaway guard, far above the expected run of under two hundred clocks
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      close_out();
    end
  end

  // main sequence
  initial begin
    {nrst, next_two_word, ext_set_en, carry_flag, digit_carry_flag} = 5'h00;
    {instr_word, working_register, mem_rdata} = 32'h0;
    bank_select_register = 4'h5;
    index_base = 12'hFF0;
    bad_count = 0;
    tests_run = 0;
    cycles = 0;
    repeat (20) @(negedge core_clk);
    nrst = 1'b1;
    exec(16'h6410, 8'h7F, 8'h80, 1'b0, 1'b0, 1'b0, 1'b0);
    exec(16'h6410, 8'h80, 8'h80, 1'b0, 1'b0, 1'b0, 1'b0);
    exec(16'h65A0, 8'hFF, 8'h01, 1'b0, 1'b0, 1'b0, 1'b1);
    exec(16'h6460, 8'h00, 8'hFF, 1'b0, 1'b0, 1'b1, 1'b0);
    exec(16'h605F, 8'h01, 8'h00, 1'b0, 1'b0, 1'b1, 1'b1);
    exec(16'h6060, 8'h10, 8'h10, 1'b0, 1'b0, 1'b0, 1'b1);
    exec(16'h6122, 8'h06, 8'h05, 1'b1, 1'b1, 1'b0, 1'b0);
    exec(16'h6205, 8'h06, 8'h05, 1'b0, 1'b0, 1'b0, 1'b0);
    exec(16'h0007, 8'hA5, 8'h00, 1'b0, 1'b0, 1'b0, 1'b0);
    exec(16'h0007, 8'hCE, 8'h00, 1'b0, 1'b0, 1'b0, 1'b0);
    exec(16'h0007, 8'h19, 8'h00, 1'b0, 1'b1, 1'b0, 1'b0);
    exec(16'h0007, 8'h12, 8'h00, 1'b1, 1'b0, 1'b0, 1'b0);
    exec(16'h0007, 8'h34, 8'h00, 1'b0, 1'b0, 1'b0, 1'b0);
    close_out();
  end
endmodule : tb_top
